/* rtl/uart_baud_map.svh */
// Register offsets, field positions, reset values and timing counts of the
// asynchronous serial unit. Included by bare name from rtl/.
`ifndef UART_BAUD_MAP_SVH
`define UART_BAUD_MAP_SVH

// ==========================================================================
// Register byte offsets
`define MODE_CTRL_OFS      8'h00
`define CLOCK_SELECT_OFS   8'h04
`define DIVISOR_CTRL_OFS   8'h08
`define TRANSMIT_BUF_OFS   8'h0C
`define RECEIVE_BUF_OFS    8'h10
`define STATUS_OFS         8'h14

// ==========================================================================
// Field positions
`define POWER_ON_BIT       7
`define TX_ENABLE_BIT      6
`define RX_ENABLE_BIT      5
`define ST_RX_FULL_BIT     0
`define ST_PAR_ERR_BIT     1
`define ST_FRM_ERR_BIT     2
`define ST_OVERRUN_BIT     3
`define ST_TX_BUSY_BIT     4
`define ST_TX_FULL_BIT     5

// ==========================================================================
// Reset values and limits
`define CLOCK_SELECT_RST   4'h0
`define DIVISOR_RST        8'hFF
`define DIVISOR_MIN        8'h08
`define BASE_SEL_MAX       4'hA
`define FRAME_LAST_BIT     4'hA
`define SAMPLE_MARGIN      9'h002
`define GAP_TICKS          2'h2

`endif

/* rtl/uart_baud_pkg.sv */
// Types shared by the asynchronous serial unit.
// Assumes nothing of its surroundings.
package uart_baud_pkg;

  // ========================================================================
  // State machines
  typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_GAP} tx_state_e;
  typedef enum logic {RX_IDLE, RX_FRAME} rx_state_e;

endpackage

/* rtl/uart_tx_fifo.sv */
// Small first-in first-out buffer with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
module uart_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Filling side
  input  wire logic             pushValid,
  output logic                  pushReady,
  input  wire logic [WIDTH-1:0] pushData,
  // Draining side
  output logic                  popValid,
  input  wire logic             popReady,
  output logic [WIDTH-1:0]      popData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
  begin : gen_check
    $error("uart_tx_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic [AW:0]      next_wrPtr;
  logic [AW:0]      next_rdPtr;
  logic             doPush;
  logic             doPop;

  // ========================================================================
  // Pointers
  always_comb
  begin
    pushReady  = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
    popValid   = wrPtr != rdPtr;
    doPush     = pushValid && pushReady;
    doPop      = popValid && popReady;
    next_wrPtr = doPush ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doPop ? rdPtr + 1'b1 : rdPtr;
    popData    = mem[rdPtr[AW-1:0]];
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  // Storage words are plain registers; no reset needed on data
  always_ff @(posedge clk_sys)
  begin
    if (doPush)
      mem[wrPtr[AW-1:0]] <= pushData;
  end

endmodule

/* rtl/uart_baud_rx_timing.sv */
// Baud generator, transmitter and receiver of an asynchronous serial unit
// with an APB register slave. Assumes an APB master on clk_sys and a remote
// serial party on rxd/txd whose rate stays inside the receive tolerance.
//
// Operation
// R01: Base clock chosen by 4-bit field, bits 3..0 of clock select register.
// R02: Divisor k accepted only from 8 to 255.
// R03: Receive sample points timed from divisor counter after start detection.
// R04: Frame is start, eight data, parity and stop: eleven bits.
// R05: Sample point lies two base clocks after bit middle.
// R06: Accepts sender rates up to 22k/(21k+2) of nominal.
// R07: Accepts sender rates down to 20k/(21k+2) of nominal.
// R08: Remote sender keeps its rate error inside the receive tolerance.
// R09: Back-to-back frames get two extra base clocks before next start.
// R10: Receiver restarts its bit timing on every start bit.
// R11: Bit rate equals base clock over twice k.
// R12: Power bit low holds base clock off and clears counters.
// R13: Transmit counter clears on first data and between continued frames.
// R14: Receive counter runs from start bit and halts after one frame.
// R15: Select code n gives system clock over two to the n, n up to 10.
//
// Local design decisions: the address map and register access over APB.
`include "uart_baud_map.svh"

module uart_baud_rx_timing #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Serial pins
  input  wire logic        rxd,
  output logic             txd
);
  if (FIFO_DEPTH < 2)
  begin : gen_check
    $error("uart_baud_rx_timing: FIFO_DEPTH must be at least 2");
  end

  // ========================================================================
  // Helpers
  function automatic logic [9:0] selMask(input logic [3:0] n);
    logic [3:0] c;
    c = (n > `BASE_SEL_MAX) ? `BASE_SEL_MAX : n;
    selMask = 10'((11'h001 << c) - 11'h001);
  endfunction

  function automatic logic evenPar(input logic [7:0] d);
    evenPar = ^d;
  endfunction

  // ========================================================================
  // Register bus
  logic        powerOn;
  logic        txEn;
  logic        rxEn;
  logic [3:0]  clkSel;
  logic [7:0]  divK;
  logic        next_powerOn;
  logic        next_txEn;
  logic        next_rxEn;
  logic [3:0]  next_clkSel;
  logic [7:0]  next_divK;
  logic [31:0] next_prdata;
  logic        access;
  logic        addrHit;
  logic        wrDone;
  logic        rdDone;
  logic        pushValid;
  logic        pushReady;
  logic        popValid;
  logic        popReady;
  logic [7:0]  popData;
  logic        rxFull;
  logic        parErr;
  logic        frmErr;
  logic        overrun;
  logic [7:0]  rxData;
  logic        txBusy;

  always_comb
  begin
    access    = psel && penable;
    addrHit   = paddr == `MODE_CTRL_OFS || paddr == `CLOCK_SELECT_OFS
             || paddr == `DIVISOR_CTRL_OFS || paddr == `TRANSMIT_BUF_OFS
             || paddr == `RECEIVE_BUF_OFS || paddr == `STATUS_OFS;
    // Writes to a disabled transmitter are dropped so the bus never hangs
    pushValid = access && pwrite && paddr == `TRANSMIT_BUF_OFS && powerOn && txEn;
    pready    = !(pushValid && !pushReady);
    pslverr   = access && !addrHit;
    wrDone    = access && pwrite && pready && addrHit;
    rdDone    = access && !pwrite && addrHit;
    next_powerOn = powerOn;
    next_txEn    = txEn;
    next_rxEn    = rxEn;
    next_clkSel  = clkSel;
    next_divK    = divK;
    if (wrDone && paddr == `MODE_CTRL_OFS)
    begin
      next_powerOn = pwdata[`POWER_ON_BIT];
      next_txEn    = pwdata[`TX_ENABLE_BIT];
      next_rxEn    = pwdata[`RX_ENABLE_BIT];
    end
    if (wrDone && paddr == `CLOCK_SELECT_OFS)
      next_clkSel = pwdata[3:0]; // R01
    if (wrDone && paddr == `DIVISOR_CTRL_OFS && pwdata[7:0] >= `DIVISOR_MIN)
      next_divK = pwdata[7:0]; // R02
    // Read data is latched in the setup cycle, so reads need no wait state
    next_prdata = prdata;
    if (psel && !penable)
    begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        `MODE_CTRL_OFS:
        begin
          next_prdata[`POWER_ON_BIT]  = powerOn;
          next_prdata[`TX_ENABLE_BIT] = txEn;
          next_prdata[`RX_ENABLE_BIT] = rxEn;
        end
        `CLOCK_SELECT_OFS: next_prdata[3:0] = clkSel;
        `DIVISOR_CTRL_OFS: next_prdata[7:0] = divK;
        `RECEIVE_BUF_OFS:  next_prdata[7:0] = rxData;
        `STATUS_OFS:
        begin
          next_prdata[`ST_RX_FULL_BIT] = rxFull;
          next_prdata[`ST_PAR_ERR_BIT] = parErr;
          next_prdata[`ST_FRM_ERR_BIT] = frmErr;
          next_prdata[`ST_OVERRUN_BIT] = overrun;
          next_prdata[`ST_TX_BUSY_BIT] = txBusy;
          next_prdata[`ST_TX_FULL_BIT] = !pushReady;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      powerOn <= 1'b0;
      txEn    <= 1'b0;
      rxEn    <= 1'b0;
      clkSel  <= `CLOCK_SELECT_RST;
      divK    <= `DIVISOR_RST;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      powerOn <= next_powerOn;
      txEn    <= next_txEn;
      rxEn    <= next_rxEn;
      clkSel  <= next_clkSel;
      divK    <= next_divK;
      prdata  <= next_prdata;
    end
  end

  // ========================================================================
  // Base clock prescaler
  logic [9:0] presc;
  logic [9:0] next_presc;
  logic       baseTick;
  logic [8:0] bitLast;
  logic [8:0] sampleAt;

  always_comb
  begin
    next_presc = powerOn ? presc + 10'h001 : 10'h000; // R12
    baseTick   = powerOn && ((presc & selMask(clkSel)) == selMask(clkSel)); // R15
    bitLast    = {divK, 1'b0} - 9'h001; // R11
    sampleAt   = {1'b0, divK} + `SAMPLE_MARGIN - 9'h001; // R05
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      presc <= 10'h000;
    else
      presc <= next_presc;
  end

  // ========================================================================
  // Transmit FIFO
  uart_tx_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .pushValid (pushValid),
    .pushReady (pushReady),
    .pushData  (pwdata[7:0]),
    .popValid  (popValid),
    .popReady  (popReady),
    .popData   (popData)
  );

  // ========================================================================
  // Transmitter
  uart_baud_pkg::tx_state_e txState;
  uart_baud_pkg::tx_state_e next_txState;
  logic [8:0]  txCnt;
  logic [8:0]  next_txCnt;
  logic [3:0]  txBit;
  logic [3:0]  next_txBit;
  logic [10:0] txShift;
  logic [10:0] next_txShift;
  logic [1:0]  gapCnt;
  logic [1:0]  next_gapCnt;
  logic        next_txd;

  always_comb
  begin
    next_txState = txState;
    next_txCnt   = txCnt;
    next_txBit   = txBit;
    next_txShift = txShift;
    next_gapCnt  = gapCnt;
    popReady     = 1'b0;
    txBusy       = txState != uart_baud_pkg::TX_IDLE;
    if (!powerOn || !txEn)
    begin
      next_txState = uart_baud_pkg::TX_IDLE; // R12
      next_txCnt   = 9'h000;
      next_txBit   = 4'h0;
      next_txShift = 11'h7FF;
      next_gapCnt  = 2'h0;
    end
    else
    begin
      unique case (txState)
        uart_baud_pkg::TX_IDLE:
          if (popValid && baseTick)
          begin
            popReady     = 1'b1;
            next_txState = uart_baud_pkg::TX_FRAME;
            next_txCnt   = 9'h000; // R13
            next_txBit   = 4'h0;
            next_txShift = {1'b1, evenPar(popData), popData, 1'b0}; // R04
          end
          else if (baseTick)
            next_txCnt = (txCnt >= bitLast) ? 9'h000 : txCnt + 9'h001; // R13
        uart_baud_pkg::TX_FRAME:
          if (baseTick)
          begin
            if (txCnt >= bitLast)
            begin
              next_txCnt = 9'h000;
              if (txBit == `FRAME_LAST_BIT)
              begin
                next_txBit  = 4'h0;
                next_gapCnt = 2'h0;
                next_txState = popValid ? uart_baud_pkg::TX_GAP
                                        : uart_baud_pkg::TX_IDLE;
              end
              else
              begin
                next_txBit   = txBit + 4'h1;
                next_txShift = {1'b1, txShift[10:1]};
              end
            end
            else
              next_txCnt = txCnt + 9'h001; // R11
          end
        uart_baud_pkg::TX_GAP:
          if (baseTick)
          begin
            if (gapCnt + 2'h1 == `GAP_TICKS) // R09
            begin
              popReady     = 1'b1;
              next_txState = uart_baud_pkg::TX_FRAME;
              next_txCnt   = 9'h000; // R13
              next_txShift = {1'b1, evenPar(popData), popData, 1'b0};
            end
            else
              next_gapCnt = gapCnt + 2'h1;
          end
      endcase
    end
    // Line idles high outside a frame and during the gap
    next_txd = (next_txState == uart_baud_pkg::TX_FRAME) ? next_txShift[0] : 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      txState <= uart_baud_pkg::TX_IDLE;
      txCnt   <= 9'h000;
      txBit   <= 4'h0;
      txShift <= 11'h7FF;
      gapCnt  <= 2'h0;
      txd     <= 1'b1;
    end
    else
    begin
      txState <= next_txState;
      txCnt   <= next_txCnt;
      txBit   <= next_txBit;
      txShift <= next_txShift;
      gapCnt  <= next_gapCnt;
      txd     <= next_txd;
    end
  end

  // ========================================================================
  // Receiver
  uart_baud_pkg::rx_state_e rxState;
  uart_baud_pkg::rx_state_e next_rxState;
  logic       rxMeta;
  logic       rxSync;
  logic       rxPrev;
  logic [8:0] rxPh;
  logic [8:0] next_rxPh;
  logic [3:0] rxBit;
  logic [3:0] next_rxBit;
  logic [9:0] rxShift;
  logic [9:0] next_rxShift;
  logic [7:0] next_rxData;
  logic       next_rxFull;
  logic       next_parErr;
  logic       next_frmErr;
  logic       next_overrun;
  logic       frameDone;
  logic       sample;
  logic       clrErr;

  always_comb
  begin
    next_rxState = rxState;
    next_rxPh    = rxPh;
    next_rxBit   = rxBit;
    next_rxShift = rxShift;
    next_rxData  = rxData;
    frameDone    = 1'b0;
    sample       = baseTick && rxPh == sampleAt; // R03 R05 R06 R07
    clrErr       = wrDone && paddr == `STATUS_OFS;
    next_rxFull  = (rdDone && paddr == `RECEIVE_BUF_OFS) ? 1'b0 : rxFull;
    next_parErr  = (clrErr && pwdata[`ST_PAR_ERR_BIT]) ? 1'b0 : parErr;
    next_frmErr  = (clrErr && pwdata[`ST_FRM_ERR_BIT]) ? 1'b0 : frmErr;
    next_overrun = (clrErr && pwdata[`ST_OVERRUN_BIT]) ? 1'b0 : overrun;
    if (!powerOn || !rxEn)
    begin
      next_rxState = uart_baud_pkg::RX_IDLE; // R12
      next_rxPh    = 9'h000;
      next_rxBit   = 4'h0;
    end
    else
    begin
      unique case (rxState)
        uart_baud_pkg::RX_IDLE:
          if (rxPrev && !rxSync)
          begin
            next_rxState = uart_baud_pkg::RX_FRAME; // R10 R14
            next_rxPh    = 9'h000;
            next_rxBit   = 4'h0;
          end
        uart_baud_pkg::RX_FRAME:
          if (baseTick)
          begin
            next_rxPh = (rxPh >= bitLast) ? 9'h000 : rxPh + 9'h001; // R03
            if (sample)
            begin
              if (rxBit == `FRAME_LAST_BIT)
              begin
                frameDone    = 1'b1;
                next_rxState = uart_baud_pkg::RX_IDLE; // R14
                next_rxPh    = 9'h000;
              end
              else if (rxBit == 4'h0 && rxSync)
              begin
                // Glitch shorter than half a bit: not a start bit
                next_rxState = uart_baud_pkg::RX_IDLE;
                next_rxPh    = 9'h000;
              end
              else
              begin
                next_rxBit   = rxBit + 4'h1;
                next_rxShift = {rxSync, rxShift[9:1]}; // R04
              end
            end
          end
      endcase
    end
    // New data and errors win over a clear in the same cycle
    if (frameDone)
    begin
      next_rxData = rxShift[8:1];
      next_overrun = overrun || next_rxFull;
      next_rxFull  = 1'b1;
      if (evenPar(rxShift[8:1]) != rxShift[9])
        next_parErr = 1'b1;
      if (!rxSync)
        next_frmErr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rxMeta  <= 1'b1;
      rxSync  <= 1'b1;
      rxPrev  <= 1'b1;
      rxState <= uart_baud_pkg::RX_IDLE;
      rxPh    <= 9'h000;
      rxBit   <= 4'h0;
      rxShift <= 10'h000;
      rxData  <= 8'h00;
      rxFull  <= 1'b0;
      parErr  <= 1'b0;
      frmErr  <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      rxMeta  <= rxd;
      rxSync  <= rxMeta;
      rxPrev  <= rxSync;
      rxState <= next_rxState;
      rxPh    <= next_rxPh;
      rxBit   <= next_rxBit;
      rxShift <= next_rxShift;
      rxData  <= next_rxData;
      rxFull  <= next_rxFull;
      parErr  <= next_parErr;
      frmErr  <= next_frmErr;
      overrun <= next_overrun;
    end
  end

endmodule

/* verification/uart_baud_rx_timing_asserts.sv */
// Port checker of the asynchronous serial unit.
// Bound to the top module; sees its ports only.
`include "uart_baud_map.svh"
module uart_baud_rx_timing_asserts (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Serial pins
  input wire logic        rxd,
  input wire logic        txd
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic        acc;
  logic        wr;
  logic        mapped;
  logic [3:0]  sel;
  logic [3:0]  next_sel;
  logic [7:0]  k;
  logic [7:0]  next_k;
  logic [19:0] low;
  logic [19:0] next_low;
  logic [19:0] bitLen;

  // ==========================================================================
  // Shadow of the timing registers, taken from committed writes
  assign acc = psel && penable;
  assign wr = acc && pready && pwrite;
  assign mapped = paddr inside {`MODE_CTRL_OFS, `CLOCK_SELECT_OFS, `DIVISOR_CTRL_OFS,
                                `TRANSMIT_BUF_OFS, `RECEIVE_BUF_OFS, `STATUS_OFS};
  assign bitLen = {11'h000, k, 1'b0} << ((sel > `BASE_SEL_MAX) ? `BASE_SEL_MAX : sel);
  always_comb
  begin
    next_sel = sel;
    next_k = k;
    next_low = txd ? 20'h00000 : low + 20'h00001;
    if (wr && paddr == `CLOCK_SELECT_OFS)
      next_sel = pwdata[3:0];
    if (wr && paddr == `DIVISOR_CTRL_OFS && pwdata[7:0] >= `DIVISOR_MIN)
      next_k = pwdata[7:0];
  end
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sel <= `CLOCK_SELECT_RST;
      k <= `DIVISOR_RST;
      low <= 20'h00000;
    end
    else
    begin
      sel <= next_sel;
      k <= next_k;
      low <= next_low;
    end
  end

  // ==========================================================================
  // Assertions
  property p_err_phase;
    pslverr |-> acc;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_err_unmapped;
    acc && !mapped |-> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no pslverr on hole");
  property p_err_mapped;
    acc && mapped |-> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("pslverr on register");
  property p_ready;
    acc && !(pwrite && paddr == `TRANSMIT_BUF_OFS) |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state on plain access");
  property p_hole_zero;
    acc && !pwrite && !mapped |-> prdata == 32'h00000000;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("hole read not zero");
  property p_sel_read;
    acc && !pwrite && paddr == `CLOCK_SELECT_OFS |-> prdata == {28'h0000000, sel};
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("clock select readback");
  property p_div_read;
    acc && !pwrite && paddr == `DIVISOR_CTRL_OFS |-> prdata == {24'h000000, k};
  endproperty
  a_div_read: assert property (p_div_read) else $error("divisor readback");
  // Low runs on txd are whole bits; the inter-frame gap only stretches high time
  property p_low_run;
    $rose(txd) |-> low != 20'h00000 && (low % bitLen) == 20'h00000;
  endproperty
  a_low_run: assert property (p_low_run) else $error("txd low run not whole bits");
endmodule

/* verification/uart_remote_party.sv */
// Remote asynchronous sender and receiver on the serial pins.
// Assumes the bench calls its tasks just after a rising clk_sys edge.
module uart_remote_party (
  // Clock
  input wire logic clk_sys,
  // Serial pins, seen from the far side
  input wire logic txd,
  output logic     rxd
);
  timeunit 1ns;
  timeprecision 100ps;

  int         bitCycles = 16;
  int         cyc = 0;
  logic [7:0] rxQ[$];
  logic       okQ[$];
  int         startQ[$];
  int         lowQ[$];

  initial rxd = 1'b1;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ==========================================================================
  // Sender: bit edges on the clock edge nearest the ideal time
  task automatic send_frame(input logic [7:0] d, input real bc, input logic badStop);
    logic [10:0] f;
    f = {~badStop, ^d, d, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      repeat ($rtoi(bc * (i + 1) + 0.5) - $rtoi(bc * i + 0.5)) @(posedge clk_sys);
    end
    if (badStop) rxd <= 1'b1;
  endtask

  task automatic glitch(input int n);
    rxd <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rxd <= 1'b1;
  endtask

  // ==========================================================================
  // Receiver: samples mid-bit, records frame starts and low runs
  always
  begin
    logic [10:0] f;
    @(negedge txd);
    startQ.push_back(cyc);
    repeat (bitCycles / 2) @(posedge clk_sys);
    for (int i = 0; i < 11; i++)
    begin
      f[i] = txd;
      if (i < 10)
        repeat (bitCycles) @(posedge clk_sys);
    end
    rxQ.push_back(f[8:1]);
    okQ.push_back(!f[0] && f[10] && !(^f[9:1]));
  end
  always
  begin
    int t;
    @(negedge txd);
    t = cyc;
    @(posedge txd);
    lowQ.push_back(cyc - t);
  end
endmodule

/* verification/tb_uart_baud_rx_timing.sv */
// Self-checking bench of the serial unit: APB master, remote party, checker.
// Assumes the design files under rtl/ and the header on the include path.
`include "uart_baud_map.svh"
module tb_uart_baud_rx_timing;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        rxd;
  logic        txd;
  int          failures = 0;
  int          samples_checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  uart_baud_rx_timing #(.FIFO_DEPTH(4)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .rxd(rxd), .txd(txd));
  uart_remote_party rp_u (.clk_sys(clk_sys), .txd(txd), .rxd(rxd));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // One transfer, then one idle cycle so psel is never driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic cfg(input logic [3:0] s, input logic [7:0] k, input logic [7:0] m);
    apb(1'b1, `CLOCK_SELECT_OFS, {28'h0000000, s});
    apb(1'b1, `DIVISOR_CTRL_OFS, {24'h000000, k});
    apb(1'b1, `MODE_CTRL_OFS, {24'h000000, m});
    rp_u.bitCycles = 2 * k * (2 ** s);
    rp_u.rxQ.delete();
    rp_u.okQ.delete();
    rp_u.startQ.delete();
    rp_u.lowQ.delete();
  endtask

  task automatic wait_q(input int n);
    for (int i = 0; i < 20000 && rp_u.rxQ.size() < n; i++)
      @(posedge clk_sys);
  endtask

  task automatic rx_take(input logic [7:0] exp);
    rdata = 32'h00000000;
    for (int i = 0; i < 400 && rdata[0] !== 1'b1; i++)
      apb(1'b0, `STATUS_OFS, 32'h00000000);
    apb(1'b0, `RECEIVE_BUF_OFS, 32'h00000000);
    check("rx data", rdata, {24'h000000, exp});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_div;
    logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h18};
    logic [31:0] rv[5] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h0};
    logic [7:0]  dw[4] = '{8'h07, 8'h08, 8'h07, 8'hFF};
    logic [7:0]  de[4] = '{8'hFF, 8'h08, 8'h08, 8'hFF};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ra[i], 32'h00000000);
      check("reset value", rdata, rv[i]);
      check("slave error", {31'h0, err}, {31'h0, i == 4});
    end
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `DIVISOR_CTRL_OFS, {24'h000000, dw[i]});
      apb(1'b0, `DIVISOR_CTRL_OFS, 32'h00000000);
      check("divisor", rdata, {24'h000000, de[i]});
    end
    $display("test reset_div done");
  endtask

  task automatic t_power_off;
    cfg(4'h0, 8'h08, 8'h60);
    apb(1'b1, `TRANSMIT_BUF_OFS, 32'h0000005A);
    repeat (400) @(posedge clk_sys);
    check("frames while off", rp_u.rxQ.size(), 0);
    check("txd while off", {31'h0, txd}, 32'h1);
    $display("test power_off done");
  endtask

  task automatic t_tx_burst;
    cfg(4'h0, 8'h08, 8'hE0);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, `TRANSMIT_BUF_OFS, 32'h00000031 + i);
      if (i == 4)
      begin
        apb(1'b0, `STATUS_OFS, 32'h00000000);
        check("fifo full", {31'h0, rdata[`ST_TX_FULL_BIT]}, 32'h1);
      end
    end
    wait_q(6);
    for (int i = 0; i < 6; i++)
    begin
      check("tx data", rp_u.rxQ[i], 8'h31 + i);
      check("tx frame", rp_u.okQ[i], 1'b1);
      if (i > 0)
        check("b2b spacing", rp_u.startQ[i] - rp_u.startQ[i - 1], 11 * 16 + 2);
    end
    $display("test tx_burst done");
  endtask

  task automatic t_sel;
    logic [3:0] sv[4] = '{4'h0, 4'h1, 4'h2, 4'h3};
    logic [7:0] kv[4] = '{8'h09, 8'h08, 8'h08, 8'h0A};
    for (int i = 0; i < 4; i++)
    begin
      cfg(sv[i], kv[i], 8'hE0);
      apb(1'b1, `TRANSMIT_BUF_OFS, 32'h000000FF);
      wait_q(1);
      check("sel data", rp_u.rxQ[0], 8'hFF);
      foreach (rp_u.lowQ[j])
        check("bit length", rp_u.lowQ[j], rp_u.bitCycles);
    end
    $display("test sel done");
  endtask

  task automatic t_rx;
    real bc[3] = '{32.0, 31.5, 33.0};
    cfg(4'h1, 8'h08, 8'hE0);
    for (int i = 0; i < 3; i++)
    begin
      fork
        rp_u.send_frame(8'hA5 ^ i, bc[i], 1'b0);
        rx_take(8'hA5 ^ i);
      join
    end
    fork
      begin
        rp_u.send_frame(8'h3C, 33.0, 1'b0);
        rp_u.send_frame(8'hC3, 33.0, 1'b0);
      end
      begin
        rx_take(8'h3C);
        rx_take(8'hC3);
      end
    join
    rp_u.glitch(6);
    repeat (400) @(posedge clk_sys);
    apb(1'b0, `STATUS_OFS, 32'h00000000);
    check("glitch ignored", {31'h0, rdata[`ST_RX_FULL_BIT]}, 32'h0);
    rp_u.send_frame(8'h11, 32.0, 1'b1);
    apb(1'b0, `STATUS_OFS, 32'h00000000);
    check("framing error", {31'h0, rdata[`ST_FRM_ERR_BIT]}, 32'h1);
    $display("test rx done");
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset_div();
    t_power_off();
    t_tx_burst();
    t_sel();
    t_rx();
    finish_test();
  end

  // Whole run needs about 7000 cycles
  initial
  begin
    #(25 * 90000);
    failures++;
    finish_test();
  end
endmodule

bind uart_baud_rx_timing uart_baud_rx_timing_asserts chk_u (.clk_sys(clk_sys), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .rxd(rxd), .txd(txd));
